// ==== dmrs_map.svh ====
// Overview of operation
// - Mode load with both banks low stores op-code
// - Settings persist; DLL restart bit self-clears
// - Mode rewrite leaves array contents untouched
// - Controller loads mode only when idle; here blocked only from a read or write command to the next read beat
// - Op-code: length, type, latency, operating mode
// - Lengths two, four, eight, both orders
// - Controller never programs reserved codes; here the op-code is passed on unchecked
// - Burst accesses at most burst length columns
// - Aligned block, wrap inside block
// - Upper column bits block, low bits start
// - Same burst length for reads and writes
// - One bit selects sequential or interleaved
// - Sequential increments, interleaved XORs a count
// - Read latency two or two and half
// - First read data at edge n plus m
// - Controller picks latency by clock frequency; here latency comes from the written op-code
// - Mode bits zero normal, restart bit DLL reset
// - Bank select picks base or extended register
`ifndef DMRS_MAP_SVH
`define DMRS_MAP_SVH
`define DMRS_BL_LSB      0
`define DMRS_BT_BIT      3
`define DMRS_CL_LSB      4
`define DMRS_OM_LSB      7
`define DMRS_DLL_BIT     8
`define DMRS_BL2         3'h1
`define DMRS_BL4         3'h2
`define DMRS_BL8         3'h3
`define DMRS_CL2         3'h2
`define DMRS_CL25        3'h6
`define DMRS_MODE_RESET  13'h0022
`define DMRS_EXT_RESET   13'h0000
`define DMRS_OFS_CMD     4'h0
`define DMRS_OFS_ADDR    4'h4
`define DMRS_OFS_STATUS  4'h8
`define DMRS_OFS_RDATA   4'hC
`endif

// ==== dmrs_pkg.sv ====
package dmrs_pkg;
  typedef enum logic [2:0] {
    DMRS_CMD_NOP   = 3'h0,
    DMRS_CMD_MODE  = 3'h1,
    DMRS_CMD_READ  = 3'h2,
    DMRS_CMD_WRITE = 3'h3
  } dmrs_cmd_t;
endpackage

// ==== dmrs_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Command, address and data lines between controller and memory
interface dmrs_link_if;
  logic [2:0]  cmd;
  logic [1:0]  bank;
  logic [12:0] addr;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        rvalid_fall;
  logic [2:0]  col_seen;
  modport mem (input cmd, bank, addr, wdata,
               output rdata, rvalid, rvalid_fall, col_seen);
  modport ctl (output cmd, bank, addr, wdata,
               input rdata, rvalid, rvalid_fall, col_seen);
endinterface
`default_nettype wire

// ==== dmrs_memory.sv ====
// Decided for this implementation: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dmrs_map.svh"
// Memory end: mode register, burst sequencer, read latency pipe
module dmrs_memory (
  // Clock and reset
  input  wire logic CLOCK_IN,
  input  wire logic RST_N_IN,
  // Link
  dmrs_link_if.mem  LINK,
  // Status
  output logic [12:0] MODE_OUT,
  output logic [12:0] EXT_MODE_OUT,
  output logic        DLL_RESET_OUT
);
  logic [12:0] mode_reg, mode_next;
  logic [12:0] ext_reg, ext_next;
  logic        dll_reg, dll_next;
  logic [7:0]  mem_reg [0:7];
  logic [7:0]  mem_next [0:7];
  logic        act_reg, act_next;
  logic        wr_reg, wr_next;
  logic [2:0]  start_reg, start_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic [3:0]  pipe_reg, pipe_next;
  logic [2:0]  colp_reg [0:3];
  logic [2:0]  colp_next [0:3];
  logic [7:0]  rd_reg, rd_next;
  logic        rv_reg, rv_next;
  logic        rvf_reg, rvf_next;
  logic [2:0]  cs_reg, cs_next;

  // Burst length in beats from length code; reserved codes run as eight
  function automatic logic [3:0] blen(input logic [2:0] c);
    case (c)
      `DMRS_BL2: blen = 4'h2;
      `DMRS_BL4: blen = 4'h4;
      default:   blen = 4'h8;
    endcase
  endfunction

  // Column within block for beat k
  function automatic logic [2:0] beat_col(input logic [12:0] m,
      input logic [2:0] s, input logic [2:0] k);
    logic [2:0] msk;
    logic [2:0] off;
    msk = 3'(blen(m[`DMRS_BL_LSB +: 3]) - 4'h1);
    if (m[`DMRS_BT_BIT])
      off = (s ^ k) & msk;
    else
      off = (s + k) & msk;
    beat_col = (s & ~msk) | off;
  endfunction

  // Next-state logic
  always_comb begin
    mode_next = mode_reg;
    ext_next  = ext_reg;
    dll_next  = 1'b0;
    for (int i = 0; i < 8; i++) mem_next[i] = mem_reg[i];
    act_next   = act_reg;
    wr_next    = wr_reg;
    start_next = start_reg;
    cnt_next   = cnt_reg;
    cs_next    = cs_reg;
    pipe_next  = {pipe_reg[2:0], 1'b0};
    colp_next[0] = 3'h0;
    for (int i = 1; i < 4; i++) colp_next[i] = colp_reg[i-1];
    if (act_reg) begin
      cs_next = beat_col(mode_reg, start_reg, cnt_reg);
      if (wr_reg)
        mem_next[cs_next] = LINK.wdata;
      else begin
        pipe_next[0] = 1'b1;
        colp_next[0] = cs_next;
      end
      if (4'(cnt_reg) + 4'h1 >= blen(mode_reg[`DMRS_BL_LSB +: 3]))
        act_next = 1'b0;
      cnt_next = cnt_reg + 3'h1;
    end
    unique case (LINK.cmd)
      dmrs_pkg::DMRS_CMD_MODE: begin
        if (LINK.bank == 2'b00) begin
          mode_next = LINK.addr;
          // Restart bit is never kept, only pulsed
          mode_next[`DMRS_DLL_BIT] = 1'b0;
          dll_next  = LINK.addr[`DMRS_DLL_BIT]
                      && (LINK.addr[12:9] == 4'h0)
                      && !LINK.addr[`DMRS_OM_LSB];
        end else if (LINK.bank == 2'b01)
          ext_next = LINK.addr;
        act_next = 1'b0;
      end
      dmrs_pkg::DMRS_CMD_READ, dmrs_pkg::DMRS_CMD_WRITE: begin
        act_next   = 1'b1;
        wr_next    = (LINK.cmd == dmrs_pkg::DMRS_CMD_WRITE);
        start_next = LINK.addr[2:0];
        cnt_next   = 3'h0;
      end
      default: ;
    endcase
    // Latency two: beat leaves pipe stage 0; 2.5: stage 1, one clock later
    rd_next  = rd_reg;
    rv_next  = 1'b0;
    rvf_next = 1'b0;
    if (mode_reg[`DMRS_CL_LSB +: 3] == `DMRS_CL25) begin
      if (pipe_reg[1]) begin
        rd_next  = mem_reg[colp_reg[1]];
        rvf_next = 1'b1;
      end
    end else if (pipe_reg[0]) begin
      rd_next = mem_reg[colp_reg[0]];
      rv_next = 1'b1;
    end
  end

  // State registers; mode held until rewritten
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      mode_reg  <= `DMRS_MODE_RESET;
      ext_reg   <= `DMRS_EXT_RESET;
      dll_reg   <= 1'b0;
      for (int i = 0; i < 8; i++) mem_reg[i] <= 8'h00;
      for (int i = 0; i < 4; i++) colp_reg[i] <= 3'h0;
      act_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      start_reg <= 3'h0;
      cnt_reg   <= 3'h0;
      pipe_reg  <= 4'h0;
      rd_reg    <= 8'h00;
      rv_reg    <= 1'b0;
      rvf_reg   <= 1'b0;
      cs_reg    <= 3'h0;
    end else begin
      mode_reg  <= mode_next;
      ext_reg   <= ext_next;
      dll_reg   <= dll_next;
      mem_reg   <= mem_next;
      colp_reg  <= colp_next;
      act_reg   <= act_next;
      wr_reg    <= wr_next;
      start_reg <= start_next;
      cnt_reg   <= cnt_next;
      pipe_reg  <= pipe_next;
      rd_reg    <= rd_next;
      rv_reg    <= rv_next;
      rvf_reg   <= rvf_next;
      cs_reg    <= cs_next;
    end
  end

  // Outputs straight from flops
  assign LINK.rdata       = rd_reg;
  assign LINK.rvalid      = rv_reg;
  assign LINK.rvalid_fall = rvf_reg;
  assign LINK.col_seen    = cs_reg;
  assign MODE_OUT         = mode_reg;
  assign EXT_MODE_OUT     = ext_reg;
  assign DLL_RESET_OUT    = dll_reg;
endmodule
`default_nettype wire

// ==== dmrs_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "dmrs_map.svh"
// Controller end: Avalon-MM slave issuing link commands
module dmrs_controller (
  // Clock and reset
  input  wire logic CLOCK_IN,
  input  wire logic RST_N_IN,
  // Avalon-MM slave
  input  wire logic [3:0]  AVS_ADDRESS_IN,
  input  wire logic        AVS_READ_IN,
  input  wire logic        AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0]      AVS_READDATA_OUT,
  output logic             AVS_WAITREQUEST_OUT,
  // Link
  dmrs_link_if.ctl         LINK
);
  logic [2:0]  cmd_reg, cmd_next;
  logic [1:0]  bank_reg, bank_next;
  logic [12:0] addr_reg, addr_next;
  logic [7:0]  wd_reg, wd_next;
  logic [7:0]  rcap_reg, rcap_next;
  logic [31:0] rdo_reg, rdo_next;
  logic        ack_reg, ack_next;
  logic        busy_reg, busy_next;

  // Command issue and register decode; one wait state per access
  always_comb begin
    cmd_next  = dmrs_pkg::DMRS_CMD_NOP;
    bank_next = bank_reg;
    addr_next = addr_reg;
    wd_next   = wd_reg;
    rcap_next = rcap_reg;
    rdo_next  = rdo_reg;
    ack_next  = 1'b0;
    busy_next = busy_reg;
    if (LINK.rvalid || LINK.rvalid_fall) rcap_next = LINK.rdata;
    if ((AVS_READ_IN || AVS_WRITE_IN) && !ack_reg) begin
      ack_next = 1'b1;
      if (AVS_WRITE_IN) begin
        unique case (AVS_ADDRESS_IN)
          `DMRS_OFS_CMD: begin
            // Mode load refused after a read or write command until the next read beat arrives
            if (!(busy_reg && AVS_WRITEDATA_IN[2:0] == 3'h1))
              cmd_next = AVS_WRITEDATA_IN[2:0];
            bank_next = AVS_WRITEDATA_IN[5:4];
          end
          `DMRS_OFS_ADDR: begin
            addr_next = AVS_WRITEDATA_IN[12:0];
            wd_next   = AVS_WRITEDATA_IN[23:16];
          end
          default: ;
        endcase
      end else begin
        unique case (AVS_ADDRESS_IN)
          `DMRS_OFS_ADDR:   rdo_next = {8'h00, wd_reg, 3'h0, addr_reg};
          `DMRS_OFS_STATUS: rdo_next = {29'h0, LINK.col_seen};
          `DMRS_OFS_RDATA:  rdo_next = {24'h0, rcap_reg};
          default:          rdo_next = 32'h0000_0000;
        endcase
      end
    end
    if (cmd_next == dmrs_pkg::DMRS_CMD_READ ||
        cmd_next == dmrs_pkg::DMRS_CMD_WRITE)
      busy_next = 1'b1;
    else if (LINK.rvalid || LINK.rvalid_fall || cmd_reg != 3'h0)
      busy_next = busy_reg && (cmd_reg != 3'h0);
  end

  // Registers
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      cmd_reg  <= 3'h0;
      bank_reg <= 2'h0;
      addr_reg <= 13'h0000;
      wd_reg   <= 8'h00;
      rcap_reg <= 8'h00;
      rdo_reg  <= 32'h0000_0000;
      ack_reg  <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      cmd_reg  <= cmd_next;
      bank_reg <= bank_next;
      addr_reg <= addr_next;
      wd_reg   <= wd_next;
      rcap_reg <= rcap_next;
      rdo_reg  <= rdo_next;
      ack_reg  <= ack_next;
      busy_reg <= busy_next;
    end
  end

  assign LINK.cmd            = cmd_reg;
  assign LINK.bank           = bank_reg;
  assign LINK.addr           = addr_reg;
  assign LINK.wdata          = wd_reg;
  assign AVS_READDATA_OUT    = rdo_reg;
  assign AVS_WAITREQUEST_OUT = !ack_reg;
endmodule
`default_nettype wire

// ==== dmrs_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches link beats against a shadow of the mode fields
module dmrs_props (
  // Clock and reset
  input wire logic        CLOCK_IN,
  input wire logic        RST_N_IN,
  // Link
  input wire logic [2:0]  cmd,
  input wire logic [1:0]  bank,
  input wire logic [12:0] addr,
  input wire logic        rvalid,
  input wire logic        rvalid_fall
);
  logic [6:0] op_reg;
  default clocking @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Shadow of the fields; reset gives length four, latency two
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN)
    if (!RST_N_IN) op_reg <= 7'h22;
    else if (cmd == 3'h1 && bank == 2'h0) op_reg <= addr[6:0];
  wire logic rd2 = cmd == 3'h2 && op_reg[6:4] == 3'h2;
  wire logic rdh = cmd == 3'h2 && op_reg[6:4] == 3'h6;
  a_first_beat_cl2: assert property (rd2 |-> ##[2:4] $rose(rvalid))
    else $error("first beat missing");
  a_two_beats: assert property (rd2 && op_reg[2:0] == 3'h1
    |-> ##[2:4] $rose(rvalid) ##0 rvalid[*2] ##1 !rvalid) else $error("len2");
  a_four_beats: assert property (rd2 && op_reg[2:0] == 3'h2
    |-> ##[2:4] $rose(rvalid) ##0 rvalid[*4] ##1 !rvalid) else $error("len4");
  a_eight_beats: assert property (rd2 && op_reg[2:0] == 3'h3
    |-> ##[2:4] $rose(rvalid) ##0 rvalid[*8] ##1 !rvalid) else $error("len8");
  a_half_first: assert property (rdh |-> ##[2:5] $rose(rvalid_fall))
    else $error("half cycle beat missing");
  a_half_no_rise: assert property (rdh |-> !rvalid[*8])
    else $error("rising beat at half latency");
  a_one_edge_only: assert property (!(rvalid && rvalid_fall))
    else $error("both beat kinds at once");
  a_write_silent: assert property (cmd == 3'h3 |->
    (!rvalid && !rvalid_fall)[*3]) else $error("read beat on write");
  c_read_cl2: cover property (rd2);
  c_read_half: cover property (rdh);
  c_write: cover property (cmd == 3'h3);
endmodule
`default_nettype wire

// ==== test_ddr_mode_register_burst_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Drives the controller over Avalon and checks beats on the link
module test_ddr_mode_register_burst_sequencer;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        wait_req, dll_o, dll_seen = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic [31:0] wd = 32'h0, rdat, rdd;
  logic [12:0] mode_o, ext_o;
  logic [7:0]  mem_m [8], got [$];
  int          miscompares = 0, check_count = 0, cyc = 0;
  dmrs_link_if link ();
  dmrs_memory dmrs_memory_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n),
    .LINK(link), .MODE_OUT(mode_o), .EXT_MODE_OUT(ext_o),
    .DLL_RESET_OUT(dll_o));
  dmrs_controller dmrs_controller_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n),
    .AVS_ADDRESS_IN(adr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wd), .AVS_READDATA_OUT(rdat),
    .AVS_WAITREQUEST_OUT(wait_req), .LINK(link));
  dmrs_props dmrs_props_inst (.CLOCK_IN(clk), .RST_N_IN(rst_n),
    .cmd(link.cmd), .bank(link.bank), .addr(link.addr),
    .rvalid(link.rvalid), .rvalid_fall(link.rvalid_fall));
  always #4 clk = ~clk;
  // Beats in arrival order; the restart pulse lasts one cycle
  always @(posedge clk) begin
    if (link.rvalid || link.rvalid_fall) got.push_back(link.rdata);
    if (dll_o === 1'b1) dll_seen <= 1'b1;
  end
  // Hang guard, well above the run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // Held until waitrequest is sampled low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do @(posedge clk); while (wait_req !== 1'b0);
    rdd = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Spacing leaves every burst finished before the next command
  task automatic lnk(input logic [2:0] c, input logic [1:0] b,
                     input logic [12:0] a, input logic [7:0] v);
    av(1'b1, 4'h4, {8'h0, v, 3'h0, a});
    av(1'b1, 4'h0, {26'h0, b, 1'b0, c});
    repeat (16) @(posedge clk);
  endtask
  function automatic logic [2:0] col(input logic [2:0] s, i, m,
                                     input logic t);
    return (s & ~m) | ((t ? s ^ i : s + i) & m);
  endfunction
  task automatic burst(input logic [2:0] bc, input logic t,
                       input logic [2:0] cl, ws, rs, input logic [7:0] v);
    logic [2:0] m;
    m = (3'h1 << bc) - 3'h1;
    lnk(3'h1, 2'h0, {6'h0, cl, t, bc}, 8'h0);
    lnk(3'h3, 2'h1, {10'h0, ws}, v);
    for (int i = 0; i <= 7; i++) if (i <= m) mem_m[col(ws, 3'(i), m, t)] = v;
    got.delete();
    lnk(3'h2, 2'h2, {10'h0, rs}, 8'h0);
    check(got.size(), 32'(m) + 1);
    for (int i = 0; i <= 7; i++)
      if (i <= m) check(got[i], mem_m[col(rs, 3'(i), m, t)]);
    av(1'b0, 4'hC, 32'h0);
    check(rdd, mem_m[col(rs, m, m, t)]);
    av(1'b0, 4'h8, 32'h0);
    check(rdd, {29'h0, col(rs, m, m, t)});
    $display("burst len code %0d type %0d done", bc, t);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    lnk(3'h3, 2'h0, 13'h0000, 8'h5A);
    lnk(3'h3, 2'h0, 13'h0004, 8'h5A);
    foreach (mem_m[k]) mem_m[k] = 8'h5A;
    got.delete();
    lnk(3'h2, 2'h0, 13'h0006, 8'h0);
    check(got.size(), 32'h4);
    for (int k = 0; k < 12; k++)
      burst(3'(k % 3 + 1), k / 3 % 2 == 1, k < 6 ? 3'h2 : 3'h6,
            3'(k + 3), 3'(k * 5), 8'(k + 16));
    lnk(3'h1, 2'h0, 13'h0122, 8'h0);
    check(dll_seen, 1'b1);
    check(mode_o, 13'h0022);
    lnk(3'h1, 2'h1, 13'h0002, 8'h0);
    check(ext_o, 13'h0002);
    check(mode_o, 13'h0022);
    av(1'b0, 4'h2, 32'h0);
    check(rdd, 32'h0);
    $display("mode register test done");
    print_verdict();
  end
endmodule
`default_nettype wire
